// *** hdl/spi_chk_pkg.sv ***
/*
  Shared constants and check-byte arithmetic for the serial command link.
  Assumes both link ends compile against this package.
*/
package spi_chk_pkg;
  localparam int          WORD_W         = 24;
  // command byte layout
  localparam int          CMD_ADDR_LSB   = 4;
  localparam int          CMD_RW_BIT     = 3;
  // status byte layout
  localparam int          STAT_CE_BIT    = 4;
  localparam int          STAT_CNT_LSB   = 2;
  localparam int          STAT_BUSY_BIT  = 1;
  localparam int          STAT_OVR_BIT   = 0;
  // auxiliary configuration register
  localparam logic [3:0]  AUX_CFG_ADDR   = 4'h6;
  localparam int          AUX_METHOD_LSB = 0;
  localparam int          AUX_CE_BIT     = 4;
  localparam logic [23:0] AUX_RESET      = 24'h000000;
  // check methods
  localparam logic [1:0]  CHK_OFF        = 2'h0;
  localparam logic [1:0]  CHK_CRC8       = 2'h1;
  localparam logic [1:0]  CHK_SUM        = 2'h2;
  localparam logic [7:0]  CRC_POLY       = 8'h07;
  localparam logic [7:0]  CRC_INIT       = 8'hFF;
  localparam logic [7:0]  SUM_INIT       = 8'h00;
  // data bytes per address, two bits each, address 0 in the low bits
  localparam logic [31:0] REG_LEN_MAP    = 32'hAAAA_9AAE;
  // host timing in core cycles
  localparam int          HALF_CYC       = 4;
  localparam int          GUARD_CYC      = 4;

  function automatic logic chk_on(input logic [1:0] m);
    chk_on = (m == CHK_CRC8) || (m == CHK_SUM);
  endfunction

  function automatic logic [7:0] chk_init(input logic [1:0] m);
    chk_init = (m == CHK_SUM) ? SUM_INIT : CRC_INIT;
  endfunction

  function automatic logic [7:0] chk_step(input logic [1:0] m,
                                          input logic [7:0] acc,
                                          input logic [7:0] b);
    logic [7:0] c;
    c = acc ^ b;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    chk_step = (m == CHK_SUM) ? 8'(acc + b) : c;
  endfunction

  function automatic logic [7:0] chk_final(input logic [1:0] m,
                                           input logic [7:0] acc);
    chk_final = (m == CHK_SUM) ? ~acc : acc;
  endfunction

  function automatic logic [1:0] reg_len(input logic [3:0] a);
    reg_len = REG_LEN_MAP[{a, 1'b0} +: 2];
  endfunction

  function automatic logic [7:0] byte_of(input logic [23:0] w,
                                         input logic [1:0]  len,
                                         input logic [1:0]  idx);
    logic [1:0] k;
    k = len - 2'h1 - idx;
    byte_of = 8'(w >> {k, 3'b000});
  endfunction
endpackage

// *** hdl/spi_chk_if.sv ***
/*
  Four-wire serial link between the command master and the device.
  Assumes a pull-up on the serial output while the device releases it.
*/
`timescale 1ns/100ps
interface spi_chk_if;
  logic select_low_input;
  logic sclk;
  logic mosi;
  logic conversion_ready_n;
  logic sdo_oe;
  logic sdo_line;

  assign sdo_line = sdo_oe ? conversion_ready_n : 1'b1;

  modport device (input select_low_input, sclk, mosi,
                  output conversion_ready_n, sdo_oe);
  modport host   (output select_low_input, sclk, mosi,
                  input sdo_line);
endinterface

// *** hdl/spi_chk_device.sv ***
/*
  Device end: frames command, data and check bytes on the serial clock,
  commits writes and holds the register words in the core domain.
  Assumes the serial clock idles high, and that chip select stays high
  at least three core cycles between frames and goes low at least three
  core cycles before the first serial clock edge.
*/
// Overview of operation
// - status byte shifts out during command byte
// - command bits 7:4 carry register address
// - command bit 3: 0 write, 1 read
// - checking only when method selects CRC8/sum
// - one check byte after last data byte
// - read: device appends check over command, data
// - master verifies check byte of read
// - master appends check byte on write
// - write check mismatch: set error, discard
// - CRC polynomial x8+x2+x+1, constant 07
// - CRC preset all ones per transaction
// - xor byte, eight shifts with feedback
// - checksum adds bytes, carry dropped
// - checksum byte is inverted sum
// - sample falling, drive rising, MSB first
// - select high: idle, output released
// - one to three data bytes per address
// - write data and check slots show conversion busy flag
`timescale 1ns/100ps
module spi_chk_device
  import spi_chk_pkg::*;
(
  // core clock and control
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // converter state
  input  wire logic [1:0]  ready_counter,
  input  wire logic        conversion_busy,
  input  wire logic        range_exceeded_flag,
  // committed writes and configuration
  output logic             wr_valid_q,
  output logic [3:0]       wr_addr_q,
  output logic [23:0]      wr_data_q,
  output logic [1:0]       check_method_select_q,
  output logic             comm_error_q,
  // serial link
  spi_chk_if.device        lnk
);
  typedef enum logic [1:0] {L_CMD, L_DATA, L_CHK} lphase_e;

  // link domain
  lphase_e     phase_q;
  logic [7:0]  shift_q;
  logic [7:0]  cmd_q;
  logic [7:0]  acc_q;
  logic [2:0]  bit_q;
  logic [1:0]  idx_q;
  logic [23:0] data_q;
  logic        wt_q;
  logic        et_q;
  logic [3:0]  wa_q;
  logic [23:0] wd_q;
  logic        live_q;
  logic        out_q;
  logic [7:0]  rx_byte;
  logic [7:0]  tx_byte;
  logic [1:0]  len;
  logic [1:0]  meth;
  logic [3:0]  addr;
  logic        rd;
  logic        byte_end;
  logic        last_data;
  logic        chk_match;

  // core domain
  logic [23:0] regs_q [16];
  logic [23:0] snap_q [16];
  logic [7:0]  status_snap_q;
  logic [1:0]  method_snap_q;
  logic [7:0]  status_now;
  logic        cs_s1_q;
  logic        cs_s2_q;
  logic [2:0]  wt_s_q;
  logic [2:0]  et_s_q;
  logic        wr_evt;
  logic        err_evt;

  // link-side decode; snapshot words are frozen while select is low
  assign rx_byte   = {shift_q[6:0], lnk.mosi};
  assign meth      = method_snap_q;
  assign addr      = cmd_q[CMD_ADDR_LSB +: 4];
  assign rd        = cmd_q[CMD_RW_BIT];
  assign len       = reg_len(addr);
  assign byte_end  = (bit_q == 3'h7);
  assign last_data = (idx_q == len - 2'h1);
  assign chk_match = (rx_byte == chk_final(meth, acc_q));

  always_comb begin
    tx_byte = {8{status_snap_q[STAT_BUSY_BIT]}};
    unique case (phase_q)
      L_CMD:  tx_byte = status_snap_q;
      L_DATA: if (rd) tx_byte = byte_of(snap_q[addr], len, idx_q);
      L_CHK:  if (rd) tx_byte = chk_final(meth, acc_q);
    endcase
  end

  // before the first rising edge the command-phase MSB is shown directly
  assign lnk.conversion_ready_n = live_q ? out_q : tx_byte[7];
  assign lnk.sdo_oe             = ~lnk.select_low_input;

  // receive framing: select high holds the framer in reset
  always_ff @(negedge lnk.sclk or posedge lnk.select_low_input) begin
    if (lnk.select_low_input) begin
      phase_q <= L_CMD;
      shift_q <= 8'h00;
      bit_q   <= 3'h0;
      idx_q   <= 2'h0;
      cmd_q   <= 8'h00;
      acc_q   <= 8'h00;
      data_q  <= 24'h000000;
    end else begin
      shift_q <= rx_byte;
      bit_q   <= bit_q + 3'h1;
      if (byte_end) begin
        unique case (phase_q)
          L_CMD: begin
            cmd_q   <= rx_byte;
            acc_q   <= chk_step(meth, chk_init(meth), rx_byte);
            idx_q   <= 2'h0;
            data_q  <= 24'h000000;
            phase_q <= L_DATA;
          end
          L_DATA: begin
            acc_q  <= chk_step(meth, acc_q, rd ? tx_byte : rx_byte);
            data_q <= {data_q[15:0], rx_byte};
            idx_q  <= idx_q + 2'h1;
            if (last_data) begin
              phase_q <= chk_on(meth) ? L_CHK : L_CMD;
            end
          end
          L_CHK: phase_q <= L_CMD;
        endcase
      end
    end
  end

  // write commit and error events, handed over by toggles
  // toggles and held words survive select going high; core reset clears
  // them while the serial clock idles, else the first toggle is unknown
  always_ff @(negedge lnk.sclk or posedge reset) begin
    if (reset) begin
      wa_q <= 4'h0;
      wd_q <= 24'h000000;
      wt_q <= 1'b0;
      et_q <= 1'b0;
    end else if (byte_end && !rd && phase_q == L_DATA && last_data
        && !chk_on(meth)) begin
      wa_q <= addr;
      wd_q <= {data_q[15:0], rx_byte};
      wt_q <= ~wt_q;
    end else if (byte_end && !rd && phase_q == L_CHK) begin
      if (chk_match) begin
        wa_q <= addr;
        wd_q <= data_q;
        wt_q <= ~wt_q;
      end else begin
        et_q <= ~et_q;
      end
    end
  end

  // transmit: output changes on the rising edge
  always_ff @(posedge lnk.sclk or posedge lnk.select_low_input) begin
    if (lnk.select_low_input) begin
      live_q <= 1'b0;
      out_q  <= 1'b0;
    end else begin
      live_q <= 1'b1;
      out_q  <= tx_byte[~bit_q];
    end
  end

  // core domain crossings
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      wt_s_q  <= 3'h0;
      et_s_q  <= 3'h0;
    end else if (clk_en) begin
      cs_s1_q <= lnk.select_low_input;
      cs_s2_q <= cs_s1_q;
      wt_s_q  <= {wt_s_q[1:0], wt_q};
      et_s_q  <= {et_s_q[1:0], et_q};
    end
  end

  assign wr_evt  = clk_en && (wt_s_q[2] != wt_s_q[1]);
  assign err_evt = clk_en && (et_s_q[2] != et_s_q[1]);

  always_comb begin
    status_now                        = 8'h00;
    status_now[STAT_CE_BIT]           = comm_error_q;
    status_now[STAT_CNT_LSB +: 2]     = ready_counter;
    status_now[STAT_BUSY_BIT]         = conversion_busy;
    status_now[STAT_OVR_BIT]          = range_exceeded_flag;
  end

  // register words and committed write outputs
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < 16; i++) begin
        regs_q[i] <= 24'h000000;
      end
      wr_valid_q            <= 1'b0;
      wr_addr_q             <= 4'h0;
      wr_data_q             <= 24'h000000;
      check_method_select_q <= AUX_RESET[AUX_METHOD_LSB +: 2];
    end else if (clk_en) begin
      wr_valid_q <= wr_evt;
      if (wr_evt) begin
        regs_q[wa_q] <= wd_q;
        wr_addr_q    <= wa_q;
        wr_data_q    <= wd_q;
        if (wa_q == AUX_CFG_ADDR) begin
          check_method_select_q <= wd_q[AUX_METHOD_LSB +: 2];
        end
      end
    end
  end

  // sticky error flag; a new error wins over a clearing write
  always_ff @(posedge core_clk) begin
    if (reset) begin
      comm_error_q <= 1'b0;
    end else if (err_evt) begin
      comm_error_q <= 1'b1;
    end else if (wr_evt && wa_q == AUX_CFG_ADDR && !wd_q[AUX_CE_BIT]) begin
      comm_error_q <= 1'b0;
    end
  end

  // snapshot refreshed only while the link is idle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < 16; i++) begin
        snap_q[i] <= 24'h000000;
      end
      status_snap_q <= 8'h00;
      method_snap_q <= CHK_OFF;
    end else if (clk_en && cs_s2_q) begin
      for (int i = 0; i < 16; i++) begin
        snap_q[i] <= regs_q[i];
      end
      snap_q[AUX_CFG_ADDR][AUX_CE_BIT] <= comm_error_q;
      status_snap_q <= status_now;
      method_snap_q <= check_method_select_q;
    end
  end
endmodule

// *** hdl/spi_chk_host.sv ***
/*
  Master end: runs one command transaction per start request, makes the
  serial clock by dividing the core clock, appends and checks check bytes.
  Assumes the caller passes the check method the device is set to.
*/
`timescale 1ns/100ps
module spi_chk_host
  import spi_chk_pkg::*;
#(
  parameter int HALF  = HALF_CYC,
  parameter int GUARD = GUARD_CYC
) (
  // core clock and control
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // request
  input  wire logic        start,
  input  wire logic        rd_not_wr,
  input  wire logic [3:0]  addr,
  input  wire logic [23:0] wr_data,
  input  wire logic [1:0]  method,
  // answer
  output logic             busy_q,
  output logic             done_q,
  output logic [23:0]      rd_data_q,
  output logic [7:0]       status_q,
  output logic             chk_err_q,
  output logic             ready_n_q,
  // serial link
  spi_chk_if.host          lnk
);
  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_HIGH, H_LOW, H_GAP} hstate_e;

  hstate_e     state_q;
  logic [7:0]  cnt_q;
  logic [2:0]  bit_q;
  logic [2:0]  idx_q;
  logic [2:0]  last_q;
  logic [7:0]  cmd_q;
  logic [23:0] wd_q;
  logic [1:0]  m_q;
  logic [1:0]  len_q;
  logic [7:0]  acc_q;
  logic [7:0]  rx_q;
  logic        cs_q;
  logic        sclk_q;
  logic        mosi_q;
  logic        sdo_s1_q;
  logic        sdo_s2_q;
  logic [7:0]  tx_byte;
  logic        cnt_end;
  logic        rd;

  assign lnk.select_low_input = cs_q;
  assign lnk.sclk             = sclk_q;
  assign lnk.mosi             = mosi_q;
  assign cnt_end = (cnt_q == 8'h00);
  assign rd      = cmd_q[CMD_RW_BIT];

  always_comb begin
    if (idx_q == 3'h0) begin
      tx_byte = cmd_q;
    end else if (idx_q <= {1'b0, len_q}) begin
      tx_byte = rd ? 8'h00 : byte_of(wd_q, len_q, 2'(idx_q - 3'h1));
    end else begin
      tx_byte = chk_final(m_q, acc_q);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sdo_s1_q  <= 1'b1;
      sdo_s2_q  <= 1'b1;
      ready_n_q <= 1'b1;
    end else if (clk_en) begin
      sdo_s1_q  <= lnk.sdo_line;
      sdo_s2_q  <= sdo_s1_q;
      ready_n_q <= sdo_s2_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q   <= H_IDLE;
      cnt_q     <= 8'h00;
      bit_q     <= 3'h0;
      idx_q     <= 3'h0;
      last_q    <= 3'h0;
      cmd_q     <= 8'h00;
      wd_q      <= 24'h000000;
      m_q       <= CHK_OFF;
      len_q     <= 2'h0;
      acc_q     <= 8'h00;
      rx_q      <= 8'h00;
      cs_q      <= 1'b1;
      sclk_q    <= 1'b1;
      mosi_q    <= 1'b0;
      busy_q    <= 1'b0;
      done_q    <= 1'b0;
      rd_data_q <= 24'h000000;
      status_q  <= 8'h00;
      chk_err_q <= 1'b0;
    end else if (clk_en) begin
      done_q <= 1'b0;
      if (!cnt_end) begin
        cnt_q <= cnt_q - 8'h01;
      end
      unique case (state_q)
        H_IDLE: if (start) begin
          cmd_q   <= {addr, rd_not_wr, 3'b000};
          wd_q    <= wr_data;
          m_q     <= method;
          len_q   <= reg_len(addr);
          last_q  <= 3'(reg_len(addr)) + {2'b00, chk_on(method)};
          idx_q   <= 3'h0;
          bit_q   <= 3'h0;
          busy_q  <= 1'b1;
          cs_q    <= 1'b0;
          cnt_q   <= 8'(GUARD - 1);
          state_q <= H_SETUP;
        end
        H_SETUP: if (cnt_end) begin
          mosi_q  <= tx_byte[7];
          cnt_q   <= 8'(HALF - 1);
          state_q <= H_HIGH;
        end
        H_HIGH: if (cnt_end) begin
          rx_q    <= {rx_q[6:0], sdo_s2_q};
          sclk_q  <= 1'b0;
          cnt_q   <= 8'(HALF - 1);
          state_q <= H_LOW;
        end
        H_LOW: if (cnt_end) begin
          sclk_q <= 1'b1;
          cnt_q  <= 8'(HALF - 1);
          bit_q  <= bit_q + 3'h1;
          if (bit_q != 3'h7) begin
            mosi_q  <= tx_byte[~(bit_q + 3'h1)];
            state_q <= H_HIGH;
          end else begin
            if (idx_q == 3'h0) begin
              status_q <= rx_q;
              acc_q    <= chk_step(m_q, chk_init(m_q), cmd_q);
            end else if (idx_q <= {1'b0, len_q}) begin
              acc_q     <= chk_step(m_q, acc_q, rd ? rx_q : tx_byte);
              rd_data_q <= {rd_data_q[15:0], rx_q};
            end else if (rd) begin
              chk_err_q <= (rx_q != chk_final(m_q, acc_q));
            end
            if (idx_q == last_q) begin
              cs_q    <= 1'b1;
              cnt_q   <= 8'(GUARD - 1);
              state_q <= H_GAP;
            end else begin
              idx_q   <= idx_q + 3'h1;
              state_q <= H_SETUP;
              cnt_q   <= 8'h00;
            end
          end
        end
        H_GAP: if (cnt_end) begin
          busy_q  <= 1'b0;
          done_q  <= 1'b1;
          state_q <= H_IDLE;
        end
        default: state_q <= H_IDLE;
      endcase
      if (state_q == H_IDLE && start) begin
        rd_data_q <= 24'h000000;
        chk_err_q <= 1'b0;
      end
    end
  end
endmodule

// *** test/spi_chk_link_sva.sv ***
/*
  Wire-level checks on the serial command link between host and device.
  Assumes it watches the shared interface signals in the core clock domain.
*/
`timescale 1ns/100ps
module spi_chk_link_sva (
  // core clock domain
  input wire logic core_clk,
  input wire logic reset,
  // serial link
  input wire logic select_low_input,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic conversion_ready_n,
  input wire logic sdo_oe,
  input wire logic sdo_line
);
  logic [7:0] fall_cnt_q;
  logic       sclk_q;
  logic       sel_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  always_ff @(posedge core_clk) begin
    sclk_q <= sclk;
    sel_q  <= select_low_input;
  end

  // count kept until the first idle cycle after the frame
  always_ff @(posedge core_clk) begin
    if (reset || (select_low_input && sel_q)) begin
      fall_cnt_q <= 8'h00;
    end else if (sclk_q && !sclk) begin
      fall_cnt_q <= fall_cnt_q + 8'h01;
    end
  end

  oe_follow_sel_a: assert property (sdo_oe == !select_low_input)
    else $error("output enable differs from select");
  idle_pullup_a: assert property (!sdo_oe |-> sdo_line)
    else $error("released line not pulled high");
  sclk_idle_a: assert property (select_low_input |-> sclk)
    else $error("serial clock not idle high outside frame");
  sel_lead_a: assert property ($fell(select_low_input) |-> sclk [*3])
    else $error("serial clock too soon after select");
  sel_gap_a: assert property ($rose(select_low_input) |->
    select_low_input [*3])
    else $error("select high gap too short");
  mosi_hold_a: assert property (!select_low_input && !sclk |->
    $stable(mosi))
    else $error("serial input moved while clock low");
  sdo_hold_a: assert property (!select_low_input && !sclk &&
    !$past(sclk) |-> $stable(conversion_ready_n))
    else $error("serial output moved while clock low");
  whole_bytes_a: assert property ($rose(select_low_input) |->
    fall_cnt_q[2:0] == 3'h0 && fall_cnt_q >= 8'h10)
    else $error("frame not whole bytes of command and data");
  stat_top_zero_a: assert property ($fell(select_low_input) |->
    !conversion_ready_n [*3])
    else $error("status top bit not zero");

  cover property ($fell(select_low_input));
  cover property ($rose(select_low_input) && fall_cnt_q == 8'h10);
  cover property ($rose(select_low_input) && fall_cnt_q == 8'h28);
endmodule

// *** test/spi_command_and_error_check_bench.sv ***
/*
  Self-checking bench: host and device joined by the link interface.
  Assumes the host makes the serial clock from the core clock.
*/
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %0t mismatch got %0h exp %0h", $time, g, e); end end
module spi_command_and_error_check_bench import spi_chk_pkg::*;;
  localparam int DLY = 1;
  logic        core_clk            = 1'b0;
  logic        reset               = 1'b0;
  logic        start               = 1'b0;
  logic        rd_not_wr           = 1'b0;
  logic [3:0]  addr                = 4'h0;
  logic [23:0] wr_data             = 24'h000000;
  logic [1:0]  method              = 2'h0;
  logic [1:0]  ready_counter       = 2'h2;
  logic        conversion_busy     = 1'b1;
  logic        range_exceeded_flag = 1'b0;
  logic        busy_q;
  logic        done_q;
  logic        chk_err_q;
  logic        ready_n_q;
  logic [23:0] rd_data_q;
  logic [7:0]  status_q;
  logic        wr_valid_q;
  logic [3:0]  wr_addr_q;
  logic [23:0] wr_data_q;
  logic [1:0]  check_method_select_q;
  logic        comm_error_q;
  logic [7:0]  mo[$];
  logic [7:0]  so[$];
  logic [7:0]  msh;
  logic [7:0]  ssh;
  logic        exp_ce              = 1'b0;
  logic [1:0]  exp_m               = 2'h0;
  int          nb                  = 0;
  int          wr_cnt              = 0;
  int          fail_count          = 0;
  int          checked             = 0;

  spi_chk_if lnk_if ();

  spi_chk_device spi_chk_device_inst (
    .core_clk              (core_clk),
    .reset                 (reset),
    .clk_en                (1'b1),
    .ready_counter         (ready_counter),
    .conversion_busy       (conversion_busy),
    .range_exceeded_flag   (range_exceeded_flag),
    .wr_valid_q            (wr_valid_q),
    .wr_addr_q             (wr_addr_q),
    .wr_data_q             (wr_data_q),
    .check_method_select_q (check_method_select_q),
    .comm_error_q          (comm_error_q),
    .lnk                   (lnk_if)
  );

  spi_chk_host spi_chk_host_inst (
    .core_clk  (core_clk),
    .reset     (reset),
    .clk_en    (1'b1),
    .start     (start),
    .rd_not_wr (rd_not_wr),
    .addr      (addr),
    .wr_data   (wr_data),
    .method    (method),
    .busy_q    (busy_q),
    .done_q    (done_q),
    .rd_data_q (rd_data_q),
    .status_q  (status_q),
    .chk_err_q (chk_err_q),
    .ready_n_q (ready_n_q),
    .lnk       (lnk_if)
  );

  spi_chk_link_sva spi_chk_link_sva_inst (
    .core_clk           (core_clk),
    .reset              (reset),
    .select_low_input   (lnk_if.select_low_input),
    .sclk               (lnk_if.sclk),
    .mosi               (lnk_if.mosi),
    .conversion_ready_n (lnk_if.conversion_ready_n),
    .sdo_oe             (lnk_if.sdo_oe),
    .sdo_line           (lnk_if.sdo_line)
  );

  always #25 core_clk = ~core_clk;

  // bytes as seen on the wire, captured at the sampling edge
  always @(negedge lnk_if.sclk) begin
    if (lnk_if.select_low_input === 1'b0) begin
      msh = {msh[6:0], lnk_if.mosi};
      ssh = {ssh[6:0], lnk_if.sdo_line};
      nb++;
      if (nb % 8 == 0) begin
        mo.push_back(msh);
        so.push_back(ssh);
      end
    end
  end

  // falling edge keeps clear of the flop update
  always @(negedge core_clk) begin
    if (wr_valid_q === 1'b1) begin
      wr_cnt++;
    end
  end

  function automatic logic [7:0] ref_chk(input logic [1:0] m,
                                         input logic [7:0] q[$]);
    logic [7:0] c;
    logic [7:0] s;
    c = 8'hFF;
    s = 8'h00;
    foreach (q[i]) begin
      s = s + q[i];
      c = c ^ q[i];
      for (int j = 0; j < 8; j++) begin
        c = c[7] ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
      end
    end
    return (m == CHK_SUM) ? ~s : c;
  endfunction

  task automatic conclude();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // one host transaction; good is low for a write the device must refuse
  task automatic xfer(input logic rd, input logic [3:0] a,
                      input logic [23:0] d, input logic [1:0] m,
                      input logic good);
    logic [7:0] q[$];
    logic [7:0] stat;
    logic       on;
    int         n;
    int         w0;
    n = (a == 4'h0) ? 2 : (a == 4'h1) ? 3 : (a == 4'h6) ? 1 : 2;
    on = (m == CHK_CRC8) || (m == CHK_SUM);
    q = {{a, rd, 3'h0}};
    for (int i = n - 1; i >= 0; i--) begin
      q.push_back(d[8*i +: 8]);
    end
    stat = {3'h0, exp_ce, ready_counter, conversion_busy,
            range_exceeded_flag};
    mo.delete();
    so.delete();
    nb = 0;
    w0 = wr_cnt;
    repeat (4) @(posedge core_clk);
    #DLY;
    start = 1'b1;
    rd_not_wr = rd;
    addr = a;
    wr_data = d;
    method = m;
    @(posedge core_clk);
    #DLY;
    start = 1'b0;
    for (int k = 0; k < 4000 && done_q !== 1'b1; k++) begin
      @(posedge core_clk);
      #DLY;
    end
    `CHK(done_q, 1'b1)
    repeat (4) @(posedge core_clk);
    if (!rd && a == 4'h6 && good) begin
      exp_ce = d[4];
      exp_m = d[1:0];
    end
    if (!rd && !good) begin
      exp_ce = 1'b1;
    end
    `CHK(mo.size(), n + 1 + int'(on))
    `CHK(mo[0], q[0])
    `CHK(so[0], stat)
    `CHK(status_q, stat)
    for (int i = 1; i <= n; i++) `CHK((rd ? so[i] : mo[i]), q[i])
    if (!rd) begin
      for (int i = 1; i <= n; i++) `CHK(so[i], {8{conversion_busy}})
    end
    if (on) `CHK((rd ? so[n+1] : mo[n+1]), ref_chk(m, q))
    `CHK(wr_cnt, w0 + int'(!rd && good))
    if (!rd && good) `CHK({wr_addr_q, wr_data_q}, {a, d})
    if (rd) `CHK({rd_data_q, chk_err_q}, {d, 1'b0})
    `CHK(comm_error_q, exp_ce)
    `CHK(check_method_select_q, exp_m)
    `CHK(ready_n_q, 1'b1)
  endtask

  // a rising reset also clears the device's link-side toggles
  initial begin
    #DLY;
    reset = 1'b1;
    repeat (8) @(posedge core_clk);
    #DLY;
    reset = 1'b0;
    xfer(1'b0, 4'h6, 24'h000001, CHK_OFF, 1'b1);
    xfer(1'b0, 4'h2, 24'h001012, CHK_CRC8, 1'b1);
    `CHK(mo[3], 8'h41)
    ready_counter = 2'h1;
    conversion_busy = 1'b0;
    range_exceeded_flag = 1'b1;
    xfer(1'b1, 4'h2, 24'h001012, CHK_CRC8, 1'b1);
    // wrong method on the host gives a wrong check byte
    xfer(1'b0, 4'h2, 24'h00ABCD, CHK_SUM, 1'b0);
    xfer(1'b1, 4'h2, 24'h001012, CHK_CRC8, 1'b1);
    xfer(1'b1, 4'h0, 24'h000000, CHK_CRC8, 1'b1);
    xfer(1'b0, 4'h6, 24'h000002, CHK_CRC8, 1'b1);
    xfer(1'b0, 4'h2, 24'h001012, CHK_SUM, 1'b1);
    `CHK(mo[3], 8'hBD)
    xfer(1'b0, 4'h1, 24'hA5B6C7, CHK_SUM, 1'b1);
    xfer(1'b1, 4'h1, 24'hA5B6C7, CHK_SUM, 1'b1);
    xfer(1'b0, 4'h6, 24'h000003, CHK_SUM, 1'b1);
    xfer(1'b0, 4'h3, 24'h00BEEF, 2'h3, 1'b1);
    xfer(1'b1, 4'h3, 24'h00BEEF, 2'h3, 1'b1);
    conclude();
  end

  // several times the expected run length
  initial begin
    #(20000 * 50);
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end
endmodule
